// ### verilog/link_pwr_pkg.sv
// constants and types for the serial-link channel power control registers
// How it works
// - status bit 2 reads one while the serial-link PLL is locked.
// - power-down bit 1 turns off converter B and its digital channels.
// - power-down bit 0 turns off converter A and its digital channels.
// - both converters down powers down the whole link, PLL and multiframe clock.
// - with B down, link A keeps running; B sample slots are undefined.
// - power-down register sits at index 0x209, resets to 0x00.
// - spare-lane bit n, bits 7 to 1, enables link-layer clocks of lane An.
// - serializer bit zero gives clocks only; one also runs extra serializers.
// - serializer n is clocked only when lanes 0 to n-1 are enabled.
package link_pwr_pkg;
    localparam int NUM_LANES = 8;
    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_STATUS   = 12'h208;
    localparam logic [11:0] IDX_CHAN_PD  = 12'h209;
    localparam logic [11:0] IDX_SPARE_A  = 12'h20A;
    localparam logic [11:0] IDX_CTRL     = 12'h20C;
    localparam logic [11:0] IDX_IRQ_STAT = 12'h20D;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h20E;
    // field positions
    localparam int STAT_PLL_LOCK = 2;
    localparam int PD_CONV_A     = 0;
    localparam int PD_CONV_B     = 1;
    localparam int SPARE_SER     = 0;
    localparam int CTRL_ENC_ON   = 0;
    localparam int EV_LOCK_GAIN  = 0;
    localparam int EV_LOCK_LOSS  = 1;
    localparam int EV_PD_WR_ON   = 2;
    localparam int EV_SPARE_WR_ON = 3;
    // reset values and bus response codes
    localparam logic [7:0] CHAN_PD_RST  = 8'h00;
    localparam logic [7:0] SPARE_A_RST  = 8'h00;
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic conv_a;
        logic conv_b;
        logic dig_a;
        logic dig_b;
        logic subsys;
        logic pll;
        logic mfc;
    } power_down_t;

    typedef struct packed {
        logic       link_a_run;
        logic       b_samples_valid;
        logic [7:0] lane_clk_en;
        logic [7:0] ser_en;
    } lane_ctrl_t;
endpackage

// ### verilog/serial_link_channel_power_ctrl.sv
// register bank and power/lane gating for the serial-link output subsystem
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module serial_link_channel_power_ctrl (
    input  wire logic                      clk_i,
    input  wire logic                      reset_n_i,
    input  wire logic                      pll_locked_i,
    input  wire logic [7:0]                lanes_required_i,
    input  wire logic                      s_axi_awvalid,
    output      logic                      s_axi_awready,
    input  wire logic [31:0]               s_axi_awaddr,
    input  wire logic                      s_axi_wvalid,
    output      logic                      s_axi_wready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    output      logic                      s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    output      logic [1:0]                s_axi_bresp,
    input  wire logic                      s_axi_arvalid,
    output      logic                      s_axi_arready,
    input  wire logic [31:0]               s_axi_araddr,
    output      logic                      s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output      logic [31:0]               s_axi_rdata,
    output      logic [1:0]                s_axi_rresp,
    output      link_pwr_pkg::power_down_t pd_o,
    output      link_pwr_pkg::lane_ctrl_t  lanes_o,
    output      logic                      irq_o
);
    logic [7:0]  chan_pd_reg;
    logic [7:0]  spare_a_reg;
    logic [7:0]  ctrl_reg;
    logic [3:0]  irq_stat_reg;
    logic [3:0]  irq_mask_reg;
    logic [3:0]  irq_stat_next;
    logic [3:0]  events;
    logic        lock_meta_reg;
    logic        lock_sync_reg;
    logic        lock_prev_reg;
    logic [11:0] wr_idx_reg;
    logic [31:0] wr_data_reg;
    logic        wr_strb0_reg;
    logic [11:0] rd_idx_reg;
    logic        rd_pend_reg;
    logic        wr_go;
    logic        wr_map;
    logic        enc_on;
    logic        both_down;
    logic [7:0]  lane_en;
    logic [7:0]  ser_want;
    logic [7:0]  ser_next;
    logic        link_up;
    logic        lower_on;

    // byte address to register index; low two bits must be zero
    function automatic logic [11:0] to_idx(input logic [31:0] a);
        to_idx = (a[1:0] == 2'h0 && a[31:14] == 18'h0) ? a[13:2] : 12'hFFF;
    endfunction

    // index is one of the mapped registers
    function automatic logic mapped(input logic [11:0] i);
        mapped = (i == link_pwr_pkg::IDX_STATUS) || (i == link_pwr_pkg::IDX_CHAN_PD) ||
                 (i == link_pwr_pkg::IDX_SPARE_A) || (i == link_pwr_pkg::IDX_CTRL) ||
                 (i == link_pwr_pkg::IDX_IRQ_STAT) || (i == link_pwr_pkg::IDX_IRQ_MASK);
    endfunction

    // lock pin is asynchronous; second stage feeds all logic
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lock_meta_reg <= 1'b0;
            lock_sync_reg <= 1'b0;
        end else begin
            lock_meta_reg <= pll_locked_i;
            lock_sync_reg <= lock_meta_reg;
        end
    end

    // lock edge detector; a pin already locked at reset counts as a gain
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lock_prev_reg <= 1'b0;
        end else begin
            lock_prev_reg <= lock_sync_reg;
        end
    end

    // write address half: taken once, held until the response is accepted
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_awready <= 1'b1;
            wr_idx_reg    <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            wr_idx_reg    <= to_idx(s_axi_awaddr);
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    // write data half: may come before, with or after the address
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_wready <= 1'b1;
            wr_data_reg  <= 32'h0000_0000;
            wr_strb0_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wr_data_reg  <= s_axi_wdata;
            wr_strb0_reg <= s_axi_wstrb[0];
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // write response: one cycle after the later half, stands until bready
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= link_pwr_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? link_pwr_pkg::RESP_OKAY : link_pwr_pkg::RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // both halves held and no answer outstanding: commit once
    assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_map = mapped(wr_idx_reg);

    // read address: one read at a time, reopened by the data handshake
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_arready <= 1'b1;
            rd_idx_reg    <= 12'h000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            rd_idx_reg    <= to_idx(s_axi_araddr);
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
        end
    end

    // decode slot: one cycle between address and data
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_pend_reg <= 1'b0;
        end else begin
            rd_pend_reg <= s_axi_arvalid && s_axi_arready;
        end
    end

    // read data from the held index; stands until rready
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= link_pwr_pkg::RESP_OKAY;
        end else if (rd_pend_reg) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(rd_idx_reg) ? link_pwr_pkg::RESP_OKAY : link_pwr_pkg::RESP_SLVERR;
            unique case (rd_idx_reg)
                    // reserved status bits read zero
                    link_pwr_pkg::IDX_STATUS:   s_axi_rdata <= {29'h0, lock_sync_reg, 2'h0};
                    link_pwr_pkg::IDX_CHAN_PD:  s_axi_rdata <= {24'h0, chan_pd_reg};
                    link_pwr_pkg::IDX_SPARE_A:  s_axi_rdata <= {24'h0, spare_a_reg};
                    link_pwr_pkg::IDX_CTRL:     s_axi_rdata <= {24'h0, ctrl_reg};
                    link_pwr_pkg::IDX_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat_reg};
                    link_pwr_pkg::IDX_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask_reg};
                    default:                    s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // channel power-down; only byte lane 0 carries data
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chan_pd_reg <= link_pwr_pkg::CHAN_PD_RST;
        end else if (wr_go && wr_strb0_reg && wr_idx_reg == link_pwr_pkg::IDX_CHAN_PD) begin
            chan_pd_reg <= wr_data_reg[7:0];
        end
    end

    // spare lanes of link A; takes effect at once, ordering is software's job
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            spare_a_reg <= link_pwr_pkg::SPARE_A_RST;
        end else if (wr_go && wr_strb0_reg && wr_idx_reg == link_pwr_pkg::IDX_SPARE_A) begin
            spare_a_reg <= wr_data_reg[7:0];
        end
    end

    // control; bit 0 turns the link encoder on
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= link_pwr_pkg::CTRL_RST;
        end else if (wr_go && wr_strb0_reg && wr_idx_reg == link_pwr_pkg::IDX_CTRL) begin
            ctrl_reg <= wr_data_reg[7:0];
        end
    end

    // interrupt mask, same layout as the status
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_mask_reg <= link_pwr_pkg::IRQ_MASK_RST;
        end else if (wr_go && wr_strb0_reg && wr_idx_reg == link_pwr_pkg::IDX_IRQ_MASK) begin
            irq_mask_reg <= wr_data_reg[3:0];
        end
    end

    assign enc_on = ctrl_reg[link_pwr_pkg::CTRL_ENC_ON];

    // events; power-down and spare-lane writes made with the encoder on are flagged, not blocked,
    // since software owns that ordering and blocking would hide its bug
    always_comb begin
        events = 4'h0;
        events[link_pwr_pkg::EV_LOCK_GAIN] = lock_sync_reg && !lock_prev_reg;
        events[link_pwr_pkg::EV_LOCK_LOSS] = !lock_sync_reg && lock_prev_reg;
        events[link_pwr_pkg::EV_PD_WR_ON] = wr_go && wr_strb0_reg && enc_on &&
                                            wr_idx_reg == link_pwr_pkg::IDX_CHAN_PD;
        events[link_pwr_pkg::EV_SPARE_WR_ON] = wr_go && wr_strb0_reg && enc_on &&
                                               wr_idx_reg == link_pwr_pkg::IDX_SPARE_A;
    end

    // write one to clear; a new event in the same cycle wins
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (wr_go && wr_strb0_reg && wr_idx_reg == link_pwr_pkg::IDX_IRQ_STAT) begin
            irq_stat_next = irq_stat_reg & ~wr_data_reg[3:0];
        end
        irq_stat_next = irq_stat_next | events;
    end

    // sticky status
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_stat_reg <= 4'h0;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    // level interrupt from the next status, so it moves with the flag
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // both converters down takes the whole link subsystem with it
    assign both_down = chan_pd_reg[link_pwr_pkg::PD_CONV_A] &&
                       chan_pd_reg[link_pwr_pkg::PD_CONV_B];

    // link layer runs only with the encoder on and a converter powered
    assign link_up = enc_on && !both_down;

    // lane enables: mode-required lanes plus spare lanes 1 to 7
    always_comb begin
        lane_en     = lanes_required_i | {spare_a_reg[7:1], 1'b0};
        ser_want    = spare_a_reg[link_pwr_pkg::SPARE_SER] ? lane_en : lanes_required_i;
        ser_next    = 8'h00;
        ser_next[0] = ser_want[0];
        lower_on    = lane_en[0];
        // a serializer only gets a clock behind a contiguous run of lanes
        for (int n = 1; n < link_pwr_pkg::NUM_LANES; n++) begin
            ser_next[n] = ser_want[n] && lower_on;
            lower_on    = lower_on && lane_en[n];
        end
    end

    // power-down outputs
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pd_o <= '0;
        end else begin
            pd_o.conv_a <= chan_pd_reg[link_pwr_pkg::PD_CONV_A];
            pd_o.dig_a  <= chan_pd_reg[link_pwr_pkg::PD_CONV_A];
            pd_o.conv_b <= chan_pd_reg[link_pwr_pkg::PD_CONV_B];
            pd_o.dig_b  <= chan_pd_reg[link_pwr_pkg::PD_CONV_B];
            pd_o.subsys <= both_down;
            pd_o.pll    <= both_down;
            pd_o.mfc    <= both_down;
        end
    end

    // lane outputs; link A run, lane clocks and serializers are off with the encoder off or the link down; B valid follows bit 1 only
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lanes_o <= '0;
        end else begin
            // link A stays up with only B down; B slots then carry junk
            lanes_o.link_a_run      <= link_up;
            lanes_o.b_samples_valid <= !chan_pd_reg[link_pwr_pkg::PD_CONV_B];
            lanes_o.lane_clk_en     <= link_up ? lane_en : 8'h00;
            lanes_o.ser_en          <= link_up ? ser_next : 8'h00;
        end
    end
endmodule

// ### tb/serial_link_channel_power_monitor.sv
// port assertions for the channel power and spare-lane register bank
`timescale 1ns/100ps
module serial_link_channel_power_monitor (
    input wire logic                      clk_i,
    input wire logic                      reset_n_i,
    input wire logic                      s_axi_awvalid,
    input wire logic                      s_axi_awready,
    input wire logic                      s_axi_wvalid,
    input wire logic                      s_axi_wready,
    input wire logic                      s_axi_bvalid,
    input wire logic                      s_axi_bready,
    input wire logic                      s_axi_arvalid,
    input wire logic                      s_axi_arready,
    input wire logic                      s_axi_rvalid,
    input wire link_pwr_pkg::power_down_t pd_o,
    input wire link_pwr_pkg::lane_ctrl_t  lanes_o
);
    // single clock domain
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // bus transfers that start a timed answer
    sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
    property p_wr_ans; s_wr_take |=> !s_axi_awready ##[0:1] s_axi_bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
    property p_rd_ans; s_rd_take |=> !s_axi_arready ##[0:1] s_axi_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
    a_b_done: assert property (p_b_done) else $error("write response not closed");
    // power-down coupling at the outputs
    property p_a_dig; pd_o.dig_a == pd_o.conv_a; endproperty
    a_a_dig: assert property (p_a_dig) else $error("digital A power mismatch");
    property p_b_dig; pd_o.dig_b == pd_o.conv_b; endproperty
    a_b_dig: assert property (p_b_dig) else $error("digital B power mismatch");
    property p_all_down;
        pd_o.conv_a && pd_o.conv_b |-> pd_o.subsys && pd_o.pll && pd_o.mfc && !lanes_o.link_a_run;
    endproperty
    a_all_down: assert property (p_all_down) else $error("link up with both down");
    property p_b_only; pd_o.conv_b && !pd_o.conv_a |-> !pd_o.subsys && !lanes_o.b_samples_valid; endproperty
    a_b_only: assert property (p_b_only) else $error("B down upset the link");
    // adjacent lane only: cheap, still catches a missing lower lane
    property p_ser_chain; (lanes_o.ser_en & ~{lanes_o.lane_clk_en[6:0], 1'b1}) == 8'h00; endproperty
    a_ser_chain: assert property (p_ser_chain) else $error("serializer above a gap");
endmodule

bind serial_link_channel_power_ctrl serial_link_channel_power_monitor i_mon (.*);

// ### tb/tb_serial_link_channel_power_ctrl.sv
// self-checking bench for the channel power and spare-lane register bank
`timescale 1ns/100ps
module tb_serial_link_channel_power_ctrl;
    logic                      clk_i = 1'b0, reset_n_i = 1'b0, lock = 1'b0, awr, wrdy, bv, arr, rv, irq;
    logic                      awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [7:0]                req = 8'h00;
    logic [3:0]                strb = 4'hF;
    logic [31:0]               awa = 32'h0, wd = 32'h0, ara = 32'h0, rdat;
    logic [1:0]                bresp, rresp, resp;
    link_pwr_pkg::power_down_t pd;
    link_pwr_pkg::lane_ctrl_t  ln;
    int                        n_fail = 0, cmp_count = 0;
    serial_link_channel_power_ctrl i_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .pll_locked_i(lock), .lanes_required_i(req), .irq_o(irq),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .pd_o(pd), .lanes_o(ln));
    // compare, bus write and bus read
    task automatic chk(input logic [31:0] g, e);
        cmp_count++;
        n_fail += (g !== e);
        if (g !== e) $display("ERROR at %0t: got %h expected %h", $time, g, e);
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic ad = 1'b0;
        logic dd = 1'b0;
        awa <= a;
        wd <= d;
        {awv, wv, br} <= 3'b111;
        while (!(ad && dd)) begin
            @(posedge clk_i);
            ad |= awv && awr;
            dd |= wv && wrdy;
            {awv, wv} <= {!ad, !dd};
        end
        do @(posedge clk_i); while (!bv);
        resp = bresp;
        br <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [31:0] a, e);
        ara <= a;
        {arv, rr} <= 2'b11;
        do @(posedge clk_i); while (!arr);
        arv <= 1'b0;
        do @(posedge clk_i); while (!rv);
        resp = rresp;
        chk(rdat, e);
        rr <= 1'b0;
        @(posedge clk_i);
    endtask
    // encoder off around every change, as software must
    task automatic cfg(input logic [31:0] a, d);
        wr(32'h830, 32'h0);
        wr(a, d);
        wr(32'h830, 32'h1);
        repeat (2) @(posedge clk_i);
    endtask
    task t_regs;
        chk(32'(pd), 32'h0);
        // byte lane 0 off: accepted, nothing written
        strb <= 4'hE;
        wr(32'h824, 32'h3);
        strb <= 4'hF;
        chk(32'(resp), 32'h0);
        rd(32'h824, 32'h0);
        chk(32'(resp), 32'h0);
        rd(32'h828, 32'h0);
        wr(32'h900, 32'h1);
        chk(32'(resp), 32'h2);
        rd(32'h900, 32'h0);
        chk(32'(resp), 32'h2);
    endtask
    task t_lock;
        lock <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(32'h820, 32'h4);
        lock <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(32'h820, 32'h0);
        chk(32'(irq), 32'h0);
        rd(32'h834, 32'h3);
    endtask
    // expected {pd, link running, B samples valid}
    // 0x03 only probes the both-down fallback; software would use the mode
    task automatic t_power;
        logic [7:0] v [3] = '{8'hFD, 8'h02, 8'h03};
        logic [8:0] e [3] = '{9'h143, 9'h0A2, 9'h1FC};
        for (int i = 0; i < 3; i++) begin
            cfg(32'h824, 32'(v[i]));
            chk(32'({pd, ln.link_a_run, ln.b_samples_valid}), 32'(e[i]));
            rd(32'h824, 32'(v[i]));
        end
        wr(32'h838, 32'h4);
        wr(32'h824, 32'h0);
        chk(32'(irq), 32'h1);
        wr(32'h834, 32'h4);
        chk(32'(irq), 32'h0);
        wr(32'h828, 32'h0);
        rd(32'h834, 32'hB);
        wr(32'h834, 32'hF);
        rd(32'h834, 32'h0);
        wr(32'h830, 32'h0);
    endtask
    // expected {lane clocks, serializers} with lane 0 required
    task automatic t_lanes;
        logic [7:0]  v [4] = '{8'h06, 8'h07, 8'h0B, 8'h0A};
        logic [15:0] e [4] = '{16'h0701, 16'h0707, 16'h0B03, 16'h0B01};
        req <= 8'h01;
        for (int i = 0; i < 4; i++) begin
            cfg(32'h828, 32'(v[i]));
            chk(32'({ln.lane_clk_en, ln.ser_en}), 32'(e[i]));
        end
    endtask
    task print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // clock, watchdog, then the scenarios
    initial forever #5 clk_i = ~clk_i;
    initial begin
        #200000 n_fail++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        t_regs();
        t_lock();
        t_power();
        t_lanes();
        print_verdict();
    end
endmodule
